// ==== verilog/hscnt_pkg.sv ====
/*
  Constants, register map and carrier types of the eight-channel high-speed
  pulse counter. Assumes a single 125 MHz clock and synchronous inputs.
*/
//
// Contract
// - There are eight independent counters, 0 to 7, each with its own mode, compare, trigger and filter set-up.
// - Single-phase mode counts rising edges of the first input only and ignores the second.
// - AB mode decodes the two phases, and with times-four set counts every edge of both phases.
// - CW/CCW mode counts up on first-input pulses and down on second-input pulses.
// - Internal mode counts a periodic tick of 1 us, 10 us, 100 us or 1 ms instead of the inputs.
// - With compare output enabled, the output port takes the configured level while the count equals the compare value.
// - With the trigger enabled, a trigger edge latches the count and the high time of the trigger is measured.
// - Every counter input is filtered with a configurable time that resets to 2 us.
// - In linear mode the count stops at the maximum going up or the minimum going down and raises overflow.
// - In ring mode counting up past the maximum loads the minimum and down past the minimum loads the maximum.
// - While the trigger is active it can hold the counter, and can separately block preset and latch.
`default_nettype none

package hscnt_pkg;

  localparam int NCNT          = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_US_NS    = 1000;
  localparam int TICK_US_CYC   = TICK_US_NS / CLK_PERIOD_NS;
  localparam int TICK_DECADE   = 10;
  localparam int FILT_DEF_NS   = 2000;
  localparam logic [15:0] FILT_DEF_CYC =
    16'((FILT_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // per-counter register index in addr[3:0], counter in addr[6:4]
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_CNT = 4'h1;
  localparam logic [3:0] REG_CMP = 4'h2;
  localparam logic [3:0] REG_MIN = 4'h3;
  localparam logic [3:0] REG_MAX = 4'h4;
  localparam logic [3:0] REG_LAT = 4'h5;
  localparam logic [3:0] REG_PW  = 4'h6;
  localparam logic [7:0] REG_STAT = 8'h80;
  localparam logic [7:0] REG_MASK = 8'h81;

  // status layout: one byte per event kind, bit n for counter n
  localparam int ST_OVF = 0;
  localparam int ST_CMP = 8;
  localparam int ST_LAT = 16;
  localparam int ST_PW  = 24;

  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [31:0] CMP_RST = 32'h0000_0000;
  localparam logic [31:0] MIN_RST = 32'h8000_0000;
  localparam logic [31:0] MAX_RST = 32'h7FFF_FFFF;
  localparam logic [31:0] CFG_RST = {FILT_DEF_CYC, 16'h0000};

  typedef enum logic [1:0] {MODE_SINGLE, MODE_AB, MODE_CWCCW, MODE_INT} hscnt_mode_t;

  typedef struct packed {
    logic [15:0] filt;
    logic [3:0]  rsvd;
    logic        en;
    logic        trig_dpl;
    logic        trig_dcnt;
    logic        trig_en;
    logic        cmp_lvl;
    logic        cmp_en;
    logic [1:0]  tb;
    logic        ring;
    logic        x4;
    hscnt_mode_t mode;
  } hscnt_cfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } hscnt_bus_t;

endpackage

`default_nettype wire

// ==== verilog/hscnt_filt.sv ====
/*
  Digital input filter for one counter input.
  Assumes the input is synchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none

module hscnt_filt
  import hscnt_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // input and filter time in cycles
  input  wire logic        din_i,
  input  wire logic [15:0] filt_i,
  // filtered level
  output logic             dout_o
);

  logic [15:0] run_q;

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      run_q  <= 16'h0000;
      dout_o <= 1'b0;
    end
    else if (din_i == dout_o)
      run_q <= 16'h0000;
    else if (17'(run_q) + 17'h00001 >= {1'b0, filt_i})
    begin
      dout_o <= din_i;
      run_q  <= 16'h0000;
    end
    else
      run_q <= run_q + 16'h0001;
  end

  a_filt_glitch: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (din_i != dout_o) && (17'(run_q) + 17'h00001 < {1'b0, filt_i})
    |=> dout_o == $past(dout_o))
    else $error("filter output moved before the filter time");

endmodule

`default_nettype wire

// ==== verilog/hscnt_tick.sv ====
/*
  Internal timebase: one-cycle ticks every 1 us, 10 us, 100 us and 1 ms.
  Assumes the 125 MHz clock_i.
*/
`timescale 1ns/1ps
`default_nettype none

module hscnt_tick
  import hscnt_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  // ticks, bit 0 = 1 us up to bit 3 = 1 ms
  output logic [3:0]      tick_o
);

  logic [6:0] us_q;
  logic [3:0] dec_q [3];
  logic [3:0] hit;

  assign hit[0] = (us_q == 7'(TICK_US_CYC - 1));

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      us_q <= 7'h00;
    else if (hit[0])
      us_q <= 7'h00;
    else
      us_q <= us_q + 7'h01;
  end

  for (genvar k = 0; k < 3; k++)
  begin : g_dec
    assign hit[k+1] = hit[k] && (dec_q[k] == 4'(TICK_DECADE - 1));
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        dec_q[k] <= 4'h0;
      else if (hit[k+1])
        dec_q[k] <= 4'h0;
      else if (hit[k])
        dec_q[k] <= dec_q[k] + 4'h1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tick_o <= 4'h0;
    else
      tick_o <= hit;
  end

  a_tick_period: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    tick_o[0] |-> ##125 tick_o[0])
    else $error("1 us tick period wrong");

endmodule

`default_nettype wire

// ==== verilog/hscnt_top.sv ====
/*
  Eight-channel high-speed pulse counter with filters, compare outputs,
  trigger latch and pulse-width measurement, plus register port and
  interrupt. Assumes all inputs synchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none

module hscnt_top
  import hscnt_pkg::*;
(
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  // register port
  input  wire hscnt_bus_t       bus_i,
  output logic [31:0]           rdata_o,
  // counter inputs
  input  wire logic [NCNT-1:0]  count_input_first_i,
  input  wire logic [NCNT-1:0]  count_input_second_i,
  input  wire logic [NCNT-1:0]  trigger_input_port_i,
  // compare outputs and interrupt
  output logic [NCNT-1:0]       cmp_out_o,
  output logic                  irq_o
);

  function automatic logic f_hit(hscnt_bus_t b, int unsigned n, logic [3:0] r);
    return !b.addr[7] && (b.addr[6:4] == 3'(n)) && (b.addr[3:0] == r);
  endfunction

  // returns {up, down} for one cycle of filtered inputs
  function automatic logic [1:0] f_step(hscnt_mode_t m, logic x4, logic a, logic b,
                                        logic ap, logic bp, logic tk);
    logic ar;
    logic af;
    logic br;
    logic bf;
    logic [1:0] s;
    ar = a & ~ap;
    af = ~a & ap;
    br = b & ~bp;
    bf = ~b & bp;
    case (m)
      MODE_SINGLE: s = {ar, 1'b0};
      MODE_AB:
        if (x4)
          s = {(ar & ~b) | (af & b) | (br & a) | (bf & ~a),
               (ar & b) | (af & ~b) | (br & ~a) | (bf & a)};
        else
          s = {ar & ~b, ar & b};
      MODE_CWCCW:  s = {ar, br};
      MODE_INT:    s = {tk, 1'b0};
      default:     s = 2'h0;
    endcase
    return s;
  endfunction

  hscnt_cfg_t  cfg_q [NCNT];
  logic [31:0] cnt_q [NCNT];
  logic [31:0] cmp_q [NCNT];
  logic [31:0] min_q [NCNT];
  logic [31:0] max_q [NCNT];
  logic [31:0] lat_q [NCNT];
  logic [31:0] pw_q  [NCNT];
  logic [31:0] stat_q;
  logic [31:0] mask_q;
  logic [31:0] ev;
  logic [3:0]  tick;

  hscnt_tick u_tick (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .tick_o  (tick)
  );

  for (genvar i = 0; i < NCNT; i++)
  begin : g_ch
    logic        a_f;
    logic        b_f;
    logic        t_f;
    logic        a_p;
    logic        b_p;
    logic        t_p;
    logic [1:0]  st;
    logic        hold;
    logic        pl_blk;
    logic        up;
    logic        dn;
    logic        wr_cnt;
    logic        at_max;
    logic        at_min;
    logic        match;
    logic        match_p;
    logic [31:0] pw_run;

    // each input filtered with the channel's own time
    hscnt_filt u_fa (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .din_i   (count_input_first_i[i]),
      .filt_i  (cfg_q[i].filt),
      .dout_o  (a_f)
    );
    hscnt_filt u_fb (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .din_i   (count_input_second_i[i]),
      .filt_i  (cfg_q[i].filt),
      .dout_o  (b_f)
    );
    hscnt_filt u_ft (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .din_i   (trigger_input_port_i[i]),
      .filt_i  (cfg_q[i].filt),
      .dout_o  (t_f)
    );

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        a_p <= 1'b0;
        b_p <= 1'b0;
        t_p <= 1'b0;
      end
      else
      begin
        a_p <= a_f;
        b_p <= b_f;
        t_p <= t_f;
      end
    end

    assign st = f_step(cfg_q[i].mode, cfg_q[i].x4, a_f, b_f, a_p, b_p, tick[cfg_q[i].tb]);
    // trigger level gates counting, preset and latch
    assign hold   = cfg_q[i].trig_en & cfg_q[i].trig_dcnt & t_f;
    assign pl_blk = cfg_q[i].trig_en & cfg_q[i].trig_dpl & t_f;
    assign up     = cfg_q[i].en & ~hold & st[1];
    assign dn     = cfg_q[i].en & ~hold & st[0] & ~st[1];
    assign wr_cnt = bus_i.we & f_hit(bus_i, i, REG_CNT) & ~pl_blk;
    assign at_max = (cnt_q[i] == max_q[i]);
    assign at_min = (cnt_q[i] == min_q[i]);
    assign match  = cfg_q[i].cmp_en & (cnt_q[i] == cmp_q[i]);

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        cfg_q[i] <= hscnt_cfg_t'(CFG_RST);
        cmp_q[i] <= CMP_RST;
        min_q[i] <= MIN_RST;
        max_q[i] <= MAX_RST;
      end
      else if (bus_i.we)
      begin
        if (f_hit(bus_i, i, REG_CFG))
          cfg_q[i] <= hscnt_cfg_t'(bus_i.wdata);
        if (f_hit(bus_i, i, REG_CMP))
          cmp_q[i] <= bus_i.wdata;
        if (f_hit(bus_i, i, REG_MIN))
          min_q[i] <= bus_i.wdata;
        if (f_hit(bus_i, i, REG_MAX))
          max_q[i] <= bus_i.wdata;
      end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        cnt_q[i] <= CNT_RST;
      else if (wr_cnt)
        cnt_q[i] <= bus_i.wdata;
      else if (up)
      begin
        if (!at_max)
          cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
        else if (cfg_q[i].ring)
          cnt_q[i] <= min_q[i];
      end
      else if (dn)
      begin
        if (!at_min)
          cnt_q[i] <= cnt_q[i] - 32'h0000_0001;
        else if (cfg_q[i].ring)
          cnt_q[i] <= max_q[i];
      end
    end

    assign ev[ST_OVF+i] = ~wr_cnt & ~cfg_q[i].ring & ((up & at_max) | (dn & at_min));
    assign ev[ST_CMP+i] = match & ~match_p;
    // latch on trigger rise, width on fall
    assign ev[ST_LAT+i] = cfg_q[i].trig_en & ~cfg_q[i].trig_dpl & t_f & ~t_p;
    assign ev[ST_PW+i]  = cfg_q[i].trig_en & ~t_f & t_p;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        cmp_out_o[i] <= 1'b0;
        match_p      <= 1'b0;
      end
      else
      begin
        cmp_out_o[i] <= cfg_q[i].cmp_en & (match ? cfg_q[i].cmp_lvl : ~cfg_q[i].cmp_lvl);
        match_p      <= match;
      end
    end

    // latch and pulse width; the width saturates rather than wraps
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        lat_q[i] <= 32'h0000_0000;
        pw_q[i]  <= 32'h0000_0000;
        pw_run   <= 32'h0000_0000;
      end
      else
      begin
        if (ev[ST_LAT+i])
          lat_q[i] <= cnt_q[i];
        if (ev[ST_PW+i])
          pw_q[i] <= pw_run;
        if (t_f & ~t_p)
          pw_run <= 32'h0000_0001;
        else if (t_f && pw_run != 32'hFFFF_FFFF)
          pw_run <= pw_run + 32'h0000_0001;
      end
    end

    a_lin_stop: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      up && at_max && !cfg_q[i].ring && !wr_cnt |=> cnt_q[i] == $past(cnt_q[i]))
      else $error("linear counter passed its maximum");

    a_ovf_flag: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ev[ST_OVF+i] |=> stat_q[ST_OVF+i] ##1 (stat_q[ST_OVF+i] || $past(bus_i.we)))
      else $error("overflow not flagged");

    a_ring_wrap: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      dn && at_min && cfg_q[i].ring && !wr_cnt |=> cnt_q[i] == $past(max_q[i]))
      else $error("ring counter did not wrap to maximum");

    a_cmp_level: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      match |=> cmp_out_o[i] == $past(cfg_q[i].cmp_lvl))
      else $error("compare output not at configured level");

    a_latch_value: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ev[ST_LAT+i] |=> lat_q[i] == $past(cnt_q[i]) ##1 stat_q[ST_LAT+i] || $past(bus_i.we))
      else $error("latch missed the count");

    a_trig_hold: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      hold && !wr_cnt |=> cnt_q[i] == $past(cnt_q[i]))
      else $error("counter moved while held by trigger");

    a_ab_dir: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      cfg_q[i].mode == MODE_AB && cfg_q[i].en && !hold && !wr_cnt && !at_max
      && a_f && !a_p && !b_f |=> cnt_q[i] == $past(cnt_q[i]) + 32'h0000_0001)
      else $error("A leading did not count up");

    a_x4_b_edge: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      cfg_q[i].mode == MODE_AB && cfg_q[i].x4 && cfg_q[i].en && !hold && !wr_cnt && !at_min
      && b_f && !b_p && !a_f && !a_p |=> cnt_q[i] == $past(cnt_q[i]) - 32'h0000_0001)
      else $error("times-four B edge did not count down");

    a_cw_down: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      cfg_q[i].mode == MODE_CWCCW && cfg_q[i].en && !hold && !wr_cnt && !at_min
      && b_f && !b_p && !(a_f && !a_p) |=> cnt_q[i] == $past(cnt_q[i]) - 32'h0000_0001)
      else $error("second input did not count down");

    a_single_b: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      cfg_q[i].mode == MODE_SINGLE && !(a_f && !a_p) && !wr_cnt |=> cnt_q[i] == $past(cnt_q[i]))
      else $error("single-phase counter moved without a first-input edge");

    a_ring_up: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      up && at_max && cfg_q[i].ring && !wr_cnt |=> cnt_q[i] == $past(min_q[i]))
      else $error("ring counter did not wrap to minimum");

    a_preset_blk: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      bus_i.we && f_hit(bus_i, i, REG_CNT) && pl_blk && !up && !dn |=> cnt_q[i] == $past(cnt_q[i]))
      else $error("preset taken while blocked by trigger");
  end

  // sticky status, a new event wins over a same-cycle clear
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stat_q <= 32'h0000_0000;
      mask_q <= 32'h0000_0000;
    end
    else
    begin
      if (bus_i.we && bus_i.addr == REG_STAT)
        stat_q <= (stat_q & ~bus_i.wdata) | ev;
      else
        stat_q <= stat_q | ev;
      if (bus_i.we && bus_i.addr == REG_MASK)
        mask_q <= bus_i.wdata;
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_o <= 32'h0000_0000;
    else if (!bus_i.re)
      rdata_o <= 32'h0000_0000;
    else if (bus_i.addr == REG_STAT)
      rdata_o <= stat_q;
    else if (bus_i.addr == REG_MASK)
      rdata_o <= mask_q;
    else if (bus_i.addr[7])
      rdata_o <= 32'h0000_0000;
    else
    begin
      case (bus_i.addr[3:0])
        REG_CFG: rdata_o <= {cfg_q[bus_i.addr[6:4]].filt, 4'h0, 12'(cfg_q[bus_i.addr[6:4]])};
        REG_CNT: rdata_o <= cnt_q[bus_i.addr[6:4]];
        REG_CMP: rdata_o <= cmp_q[bus_i.addr[6:4]];
        REG_MIN: rdata_o <= min_q[bus_i.addr[6:4]];
        REG_MAX: rdata_o <= max_q[bus_i.addr[6:4]];
        REG_LAT: rdata_o <= lat_q[bus_i.addr[6:4]];
        REG_PW:  rdata_o <= pw_q[bus_i.addr[6:4]];
        default: rdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== tb/hscnt_enc.sv ====
/*
  Encoder and pulse-train source for one counter's two input lines.
  Assumes the bench holds quad_i and dir_i steady for a whole run.
*/
`timescale 1ns/1ps
`default_nettype none

module hscnt_enc
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  // run request, each step lasts hold_i+1 cycles
  input  wire logic       go_i,
  input  wire logic       quad_i,
  input  wire logic       dir_i,
  input  wire logic [7:0] steps_i,
  input  wire logic [7:0] hold_i,
  // lines towards the counter, busy flag towards the bench
  output logic            a_o,
  output logic            b_o,
  output logic            busy_o
);
  logic [7:0] left_q;
  logic [7:0] wait_q;
  logic [1:0] ph_q;

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      left_q <= 8'h00;
      wait_q <= 8'h00;
      ph_q   <= 2'h0;
    end
    else if (go_i)
    begin
      left_q <= steps_i;
      wait_q <= hold_i;
    end
    else if (left_q != 8'h00)
    begin
      if (wait_q != 8'h00)
        wait_q <= wait_q - 8'h01;
      else
      begin
        wait_q <= hold_i;
        left_q <= left_q - 8'h01;
        // pulse runs touch bit 0 only, so a later quadrature run starts from 00
        ph_q   <= !quad_i ? (ph_q ^ 2'h1) : (dir_i ? ph_q - 2'h1 : ph_q + 2'h1);
      end
    end
  end

  // gray sequence 00,10,11,01 makes the first line lead when counting up
  assign a_o    = quad_i ? (ph_q[1] ^ ph_q[0]) : (ph_q[0] & !dir_i);
  assign b_o    = quad_i ? ph_q[1] : (ph_q[0] & dir_i);
  assign busy_o = left_q != 8'h00;
endmodule

`default_nettype wire

// ==== tb/high_speed_pulse_counter_bench.sv ====
/*
  Self-checking bench of the eight-channel pulse counter.
  Assumes hscnt_pkg, hscnt_top and hscnt_enc are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module high_speed_pulse_counter_bench
  import hscnt_pkg::*;
;
  localparam logic [31:0] EN = 32'h0000_0800;
  localparam logic [31:0] F2 = 32'h0002_0000;

  logic            clock_i;
  logic            rst_b_i;
  hscnt_bus_t      bus_q;
  logic [31:0]     rdata;
  logic [NCNT-1:0] in1_q, in2_q, trig_q, cmp_out;
  logic            irq, go_q, quad_q, dir_q, enc_a, enc_b, enc_busy;
  logic [7:0]      steps_q;
  logic [2:0]      sel_q;
  int              n_mismatch, samples_checked;

  hscnt_top DUT (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus_q), .rdata_o(rdata),
    .count_input_first_i(in1_q | (8'(enc_a) << sel_q)),
    .count_input_second_i(in2_q | (8'(enc_b) << sel_q)),
    .trigger_input_port_i(trig_q), .cmp_out_o(cmp_out), .irq_o(irq));

  hscnt_enc enc (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .go_i(go_q), .quad_i(quad_q), .dir_i(dir_q),
    .steps_i(steps_q), .hold_i(8'h03), .a_o(enc_a), .b_o(enc_b), .busy_o(enc_busy));

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  function automatic logic [7:0] ad(input int n, input logic [3:0] r);
    return {1'b0, 3'(n), r};
  endfunction

  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus_q <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clock_i);
    bus_q.we <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    bus_q <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge clock_i);
    bus_q.re <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  task automatic rng(input string what, input logic [7:0] a, input int lo, input int hi);
    logic [31:0] d;
    rd(a, d);
    samples_checked++;
    if ((d >= lo && d <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", what, lo, hi, d);
    end
  endtask

  task automatic run_enc(input int n, input logic q, input logic dir, input int steps);
    int k;
    @(posedge clock_i);
    sel_q <= 3'(n);
    quad_q <= q;
    dir_q <= dir;
    steps_q <= 8'(steps);
    go_q <= 1'b1;
    @(posedge clock_i);
    go_q <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clock_i);
      k++;
    end while (enc_busy !== 1'b0 && k < 1000);
    if (k >= 1000)
    begin
      n_mismatch++;
      $display("CHECK FAILED encoder run expected idle seen busy");
      print_verdict();
    end
    // filter plus count latency
    repeat (8) @(posedge clock_i);
  endtask

  task automatic t_reset();
    rchk("cfg0", ad(0, REG_CFG), {16'(2000 / 8), 16'h0000});
    rchk("cfg7", ad(7, REG_CFG), {16'(2000 / 8), 16'h0000});
    rchk("max7", ad(7, REG_MAX), 32'h7FFF_FFFF);
    wr(ad(6, REG_CNT), 32'h0000_1234);
    rchk("cnt7", ad(7, REG_CNT), 32'h0000_0000);
    rchk("cnt6", ad(6, REG_CNT), 32'h0000_1234);
    wr(8'h90, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h90, 32'h0000_0000);
  endtask

  task automatic t_single();
    wr(ad(0, REG_CFG), EN | F2);
    run_enc(0, 1'b0, 1'b0, 10);
    rchk("single up", ad(0, REG_CNT), 32'h0000_0005);
    run_enc(0, 1'b0, 1'b1, 6);
    rchk("single second", ad(0, REG_CNT), 32'h0000_0005);
    wr(ad(0, REG_CFG), EN | 32'h000A_0000);
    @(posedge clock_i);
    in1_q[0] <= 1'b1;
    repeat (3) @(posedge clock_i);
    in1_q[0] <= 1'b0;
    repeat (20) @(posedge clock_i);
    rchk("glitch", ad(0, REG_CNT), 32'h0000_0005);
    @(posedge clock_i);
    in1_q[0] <= 1'b1;
    repeat (20) @(posedge clock_i);
    in1_q[0] <= 1'b0;
    repeat (20) @(posedge clock_i);
    rchk("steady", ad(0, REG_CNT), 32'h0000_0006);
  endtask

  task automatic t_ab_cw();
    wr(ad(1, REG_CFG), EN | F2 | 32'h1);
    run_enc(1, 1'b1, 1'b0, 8);
    rchk("ab up", ad(1, REG_CNT), 32'h0000_0002);
    run_enc(1, 1'b1, 1'b1, 4);
    rchk("ab down", ad(1, REG_CNT), 32'h0000_0001);
    wr(ad(1, REG_CFG), EN | F2 | 32'h5);
    run_enc(1, 1'b1, 1'b0, 4);
    rchk("x4 up", ad(1, REG_CNT), 32'h0000_0005);
    run_enc(1, 1'b1, 1'b1, 8);
    rchk("x4 down", ad(1, REG_CNT), 32'hFFFF_FFFD);
    wr(ad(2, REG_CFG), EN | F2 | 32'h2);
    run_enc(2, 1'b0, 1'b0, 6);
    rchk("cw", ad(2, REG_CNT), 32'h0000_0003);
    run_enc(2, 1'b0, 1'b1, 10);
    rchk("ccw", ad(2, REG_CNT), 32'hFFFF_FFFE);
  endtask

  // the slowest timebase only gets a window shorter than its period: at most one tick
  task automatic t_int();
    for (int tb = 0; tb < 4; tb++)
    begin
      wr(ad(3, REG_CFG), F2 | 32'h3);
      wr(ad(3, REG_CNT), 32'h0);
      wr(ad(3, REG_CFG), EN | F2 | 32'h3 | 32'(tb << 4));
      repeat (tb < 3 ? 250 * 10 ** tb : 25000) @(posedge clock_i);
      rng("tick", ad(3, REG_CNT), tb < 3 ? 1 : 0, tb < 3 ? 3 : 1);
    end
  endtask

  task automatic t_lim();
    logic [31:0] d;
    wr(ad(4, REG_MIN), 32'h0);
    wr(ad(4, REG_MAX), 32'h3);
    wr(ad(4, REG_CMP), 32'h2);
    wr(ad(4, REG_CFG), EN | F2 | 32'hC0);
    wr(ad(4, REG_CNT), 32'h1);
    run_enc(4, 1'b0, 1'b0, 2);
    chk("cmp hit", 32'h1, {31'h0, cmp_out[4]});
    run_enc(4, 1'b0, 1'b0, 4);
    chk("cmp miss", 32'h0, {31'h0, cmp_out[4]});
    rchk("linear stop", ad(4, REG_CNT), 32'h0000_0003);
    rd(REG_STAT, d);
    chk("ovf cmp stat", 32'h0000_1010, d & 32'h0000_1010);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(REG_MASK, 32'h0000_0010);
    #1 chk("irq on", 32'h1, {31'h0, irq});
    wr(REG_STAT, 32'h0000_0010);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    wr(ad(4, REG_CFG), EN | F2 | 32'hA);
    run_enc(4, 1'b0, 1'b0, 2);
    rchk("ring up", ad(4, REG_CNT), 32'h0000_0000);
    run_enc(4, 1'b0, 1'b1, 2);
    rchk("ring down", ad(4, REG_CNT), 32'h0000_0003);
  endtask

  task automatic t_trig();
    logic [31:0] d;
    wr(ad(5, REG_CFG), EN | F2 | 32'h100);
    wr(ad(5, REG_CNT), 32'h7);
    trig_q[5] <= 1'b1;
    repeat (30) @(posedge clock_i);
    trig_q[5] <= 1'b0;
    repeat (8) @(posedge clock_i);
    rchk("latch", ad(5, REG_LAT), 32'h0000_0007);
    rng("width", ad(5, REG_PW), 29, 31);
    rd(REG_STAT, d);
    chk("trig stat", 32'h2020_0000, d & 32'h2020_0000);
    wr(ad(5, REG_CFG), EN | F2 | 32'h700);
    wr(ad(5, REG_CNT), 32'h9);
    trig_q[5] <= 1'b1;
    repeat (8) @(posedge clock_i);
    run_enc(5, 1'b0, 1'b0, 4);
    wr(ad(5, REG_CNT), 32'h63);
    trig_q[5] <= 1'b0;
    repeat (8) @(posedge clock_i);
    rchk("held", ad(5, REG_CNT), 32'h0000_0009);
    rchk("no latch", ad(5, REG_LAT), 32'h0000_0007);
  endtask

  initial
  begin
    rst_b_i = 1'b0;
    bus_q = '0;
    in1_q = '0;
    in2_q = '0;
    trig_q = '0;
    go_q = 1'b0;
    quad_q = 1'b0;
    dir_q = 1'b0;
    steps_q = 8'h00;
    sel_q = 3'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_single();
    t_ab_cw();
    t_int();
    t_lim();
    t_trig();
    print_verdict();
  end
endmodule

`default_nettype wire
